// ===== design/pmc_clk_gen.sv
// Oscillator model: start-up delay, then a square level with a falling-edge pulse.
module pmc_clk_gen
    import pmc_pkg::*;
#(
    parameter int HW        = 16,
    parameter int START_CYC = 1000
)
(
    // Clock and reset
    input  wire logic          ref_clk_i,
    input  wire logic          rst_n_i,
    // Control
    input  wire logic          en_i,
    input  wire logic [HW-1:0] half_i,
    // Clock out
    output logic               lvl_o,
    output logic               fall_o,
    output logic               ready_o
);
    localparam int SW = $clog2(START_CYC + 1);

    typedef struct packed {
        logic [HW-1:0] cnt;
        logic [SW-1:0] st;
        logic          lvl;
        logic          fall;
        logic          ready;
    } pmc_gen_s;

    pmc_gen_s q;
    pmc_gen_s d;

    always_comb
    begin
        d = q;
        d.fall = 1'b0;
        if (!en_i)
        begin
            d.st = '0;
            d.cnt = '0;
            d.ready = 1'b0;
            d.lvl = 1'b0;
            d.fall = q.lvl;
        end
        else if (!q.ready)
        begin
            if (q.st == SW'(START_CYC - 1))
                d.ready = 1'b1;
            else
                d.st = q.st + SW'(1);
        end
        // A shortened half period takes effect at once, without a restart.
        else if (q.cnt >= half_i - HW'(1))
        begin
            d.cnt = '0;
            d.lvl = ~q.lvl;
            d.fall = q.lvl;
        end
        else
            d.cnt = q.cnt + HW'(1);
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            q <= '0;
        else
            q <= d;
    end

    assign lvl_o = q.lvl;
    assign fall_o = q.fall;
    assign ready_o = q.ready;
endmodule

// ===== design/pmc_pkg.sv
// Constants, types and helper functions of the power mode and clock output controller.
// Operation
// - Mode is active, idle, sleep or standby from receiver, oscillator, battery and timer bits.
// - Entering idle starts the crystal; after ramp-up a 1 MHz clock is output.
// - The fast clock divider may be rewritten at any time without a mode change.
// - Output stays low while the crystal starts or is off, unless slow is selected.
// - The low frequency select bit outputs the 32 kHz RC clock on the pin.
// - After power-on reset the device sleeps and drives the slow clock.
// - Setting oscillator enable or receiver enable returns the output to the fast clock.
// - Clock out disable resets to 0; when set no clock is output.
// - Every phase lasts at least half a fast period; one longer low phase allowed. Here a high phase is cut short when the selected generator stops.
// - Switching acts on falling edges of both clocks, within one slow plus fast period.
// - Switching needs both clocks running; host keeps the wake timer enabled.
// - Returning to fast waits for crystal start-up detected in hardware.
// - The wake timer calibrates each time its enable bit is set. Here it skips that calibration while calibration disable is set.
// - On timeout the wake timer restarts until its enable is cleared.
// - The wake timer recalibrates about every 30 seconds while calibration is enabled.
// - Calibration disable resets to 0; setting it stops further recalibration.
// - With wake on interrupt set, an interrupt event wakes the device to fast clock.
// - Calibration disable sits at bit 4 of the extended features word.
package pmc_pkg;
    localparam int REF_HZ = 100_000_000;
    localparam int XTAL_HZ = 10_000_000;
    localparam int XTAL_HALF = REF_HZ / (2 * XTAL_HZ);
    localparam int SLOW_HZ = 32_000;
    localparam int SLOW_HALF = REF_HZ / (2 * SLOW_HZ);
    localparam int XTAL_START_US = 1000;
    localparam int XTAL_START_CYC = XTAL_START_US * (REF_HZ / 1_000_000);
    localparam int RC_START_US = 10;
    localparam int RC_START_CYC = RC_START_US * (REF_HZ / 1_000_000);
    localparam int RECAL_S = 30;
    localparam int RECAL_TICKS = RECAL_S * SLOW_HZ;
    localparam int CAL_TICKS = 4;
    localparam int HALF_W = 16;
    localparam int ADDR_W = 5;
    localparam logic [4:0] OFF_CTRL = 5'h00;
    localparam logic [4:0] OFF_DIV = 5'h04;
    localparam logic [4:0] OFF_EXTF = 5'h08;
    localparam logic [4:0] OFF_WTPER = 5'h0C;
    localparam logic [4:0] OFF_STAT = 5'h10;
    localparam int CTRL_RX = 0;
    localparam int CTRL_OSC = 1;
    localparam int CTRL_BAT = 2;
    localparam int CTRL_WTE = 3;
    localparam int CTRL_DIS = 4;
    localparam int CTRL_LF = 5;
    localparam int CTRL_WOI = 6;
    localparam int EXTF_CAL_DIS = 4;
    localparam logic [6:0] CTRL_RST = 7'h28;
    localparam logic [2:0] DIV_RST = 3'h5;
    localparam logic [15:0] WTPER_RST = 16'h0100;

    typedef enum logic [1:0] {
        PMC_STANDBY = 2'h0,
        PMC_SLEEP   = 2'h1,
        PMC_IDLE    = 2'h2,
        PMC_ACTIVE  = 2'h3
    } pmc_mode_e;

    typedef enum logic [1:0] {
        PMC_MX_OFF  = 2'h0,
        PMC_MX_FAST = 2'h1,
        PMC_MX_SLOW = 2'h2
    } pmc_mux_e;

    function automatic pmc_mode_e pmc_decode_mode(input logic rx, input logic osc,
                                                 input logic eb, input logic et);
        if (osc)
            return rx ? PMC_ACTIVE : PMC_IDLE;
        return (eb || et) ? PMC_SLEEP : PMC_STANDBY;
    endfunction

    // Crystal divide ratio per divider code; code 5 gives 1 MHz.
    function automatic logic [HALF_W-1:0] pmc_fast_half(input logic [2:0] div);
        logic [7:0] r;
        r = 8'h01;
        case (div)
            3'h0: r = 8'h01;
            3'h1: r = 8'h02;
            3'h2: r = 8'h03;
            3'h3: r = 8'h04;
            3'h4: r = 8'h05;
            3'h5: r = 8'h0A;
            3'h6: r = 8'h14;
            default: r = 8'h32;
        endcase
        return HALF_W'(XTAL_HALF) * HALF_W'(r);
    endfunction
endpackage

// ===== design/pmc_top.sv
// Power mode decode and dual clock output, glitch-free except when the selected generator stops, with wake-up timer.
module pmc_top
    import pmc_pkg::*;
#(
    parameter int XTAL_START = XTAL_START_CYC,
    parameter int RECAL      = RECAL_TICKS
)
(
    // Clock and reset
    input  wire logic              ref_clk_i,
    input  wire logic              rst_n_i,
    // Register port
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [31:0]       wr_data_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic [31:0]            rd_data_o,
    // Device events
    input  wire logic              irq_event_i,
    // Clock pin and mode outputs
    output logic                   clk_out_o,
    output logic [1:0]             mode_o,
    output logic                   xtal_on_o,
    output logic                   rc_on_o,
    output logic                   wake_tmo_o
);
    typedef struct packed {
        logic        rx_en;
        logic        osc_en;
        logic        eb;
        logic        et;
        logic        dc;
        logic        lf;
        logic        ewi;
        logic [2:0]  div;
        logic        cal_dis;
        logic [15:0] wt_per;
        logic        wake;
        pmc_mux_e    mx;
        logic        clk_out;
        pmc_mode_e   mode;
        logic        xtal_on;
        logic        rc_on;
        logic        tmo;
        logic [31:0] rd_data;
    } pmc_state_s;

    pmc_state_s q;
    pmc_state_s d;

    logic f_lvl;
    logic f_fall;
    logic xtal_rdy;
    logic s_lvl;
    logic s_fall;
    logic rc_rdy;
    logic cal_busy;
    logic wt_tmo;
    logic osc_eff;
    logic xtal_en;
    logic want_slow;
    logic fast_ok;
    logic slow_ok;

    // Crystal oscillator and fast clock divider.
    pmc_clk_gen #(
        .HW        (HALF_W),
        .START_CYC (XTAL_START)
    ) u_fast (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .en_i      (xtal_en),
        .half_i    (pmc_fast_half(q.div)),
        .lvl_o     (f_lvl),
        .fall_o    (f_fall),
        .ready_o   (xtal_rdy)
    );

    // RC oscillator of the wake-up timer, which only runs while the timer is enabled.
    pmc_clk_gen #(
        .HW        (HALF_W),
        .START_CYC (RC_START_CYC)
    ) u_slow (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .en_i      (q.et),
        .half_i    (HALF_W'(SLOW_HALF)),
        .lvl_o     (s_lvl),
        .fall_o    (s_fall),
        .ready_o   (rc_rdy)
    );

    pmc_wake_timer #(
        .RECAL      (RECAL)
    ) u_wt (
        .ref_clk_i  (ref_clk_i),
        .rst_n_i    (rst_n_i),
        .en_i       (q.et),
        .tick_i     (s_fall),
        .period_i   (q.wt_per),
        .cal_dis_i  (q.cal_dis),
        .cal_busy_o (cal_busy),
        .timeout_o  (wt_tmo)
    );

    always_comb
    begin
        osc_eff = q.osc_en || q.wake;
        xtal_en = osc_eff || q.rx_en;
        want_slow = q.lf && !xtal_en;
        fast_ok = !want_slow && xtal_rdy;
        slow_ok = want_slow && rc_rdy;
    end

    always_comb
    begin
        d = q;
        d.tmo = wt_tmo;
        d.rd_data = 32'h0000_0000;
        if (wr_i)
        begin
            case (addr_i)
                OFF_CTRL:
                begin
                    d.rx_en = wr_data_i[CTRL_RX];
                    d.osc_en = wr_data_i[CTRL_OSC];
                    d.eb = wr_data_i[CTRL_BAT];
                    d.et = wr_data_i[CTRL_WTE];
                    d.dc = wr_data_i[CTRL_DIS];
                    d.lf = wr_data_i[CTRL_LF];
                    d.ewi = wr_data_i[CTRL_WOI];
                    d.wake = 1'b0;
                end
                OFF_DIV:
                    d.div = wr_data_i[2:0];
                OFF_EXTF:
                    d.cal_dis = wr_data_i[EXTF_CAL_DIS];
                OFF_WTPER:
                    d.wt_per = wr_data_i[15:0];
                default:
                begin
                end
            endcase
        end
        // A wake event in the cycle of a control write still wins.
        if (irq_event_i && q.ewi)
            d.wake = 1'b1;
        d.mode = pmc_decode_mode(q.rx_en, osc_eff, q.eb, q.et);
        d.xtal_on = xtal_en;
        d.rc_on = q.et;
        // Source changes on falling edges, or goes off at once when its generator stops, passing through an all-low phase.
        unique case (q.mx)
            PMC_MX_OFF:
            begin
                if (fast_ok && f_fall)
                    d.mx = PMC_MX_FAST;
                else if (slow_ok && s_fall)
                    d.mx = PMC_MX_SLOW;
            end
            PMC_MX_FAST:
            begin
                if (!xtal_rdy || (!fast_ok && f_fall))
                    d.mx = PMC_MX_OFF;
            end
            PMC_MX_SLOW:
            begin
                if (!rc_rdy || (!slow_ok && s_fall))
                    d.mx = PMC_MX_OFF;
            end
            default:
                d.mx = PMC_MX_OFF;
        endcase
        d.clk_out = !q.dc && ((q.mx == PMC_MX_FAST && f_lvl)
                   || (q.mx == PMC_MX_SLOW && s_lvl));
        if (rd_i)
        begin
            case (addr_i)
                OFF_CTRL:
                    d.rd_data = {25'h0, q.ewi, q.lf, q.dc, q.et, q.eb, q.osc_en, q.rx_en};
                OFF_DIV:
                    d.rd_data = {29'h0, q.div};
                OFF_EXTF:
                    d.rd_data = {27'h0, q.cal_dis, 4'h0};
                OFF_WTPER:
                    d.rd_data = {16'h0, q.wt_per};
                OFF_STAT:
                    d.rd_data = {24'h0, q.wake, cal_busy, q.mx, rc_rdy, xtal_rdy, q.mode};
                default:
                    d.rd_data = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            q <= '0;
            {q.ewi, q.lf, q.dc, q.et, q.eb, q.osc_en, q.rx_en} <= CTRL_RST;
            q.div <= DIV_RST;
            q.wt_per <= WTPER_RST;
            q.mx <= PMC_MX_OFF;
            q.mode <= PMC_STANDBY;
        end
        else
            q <= d;
    end

    assign rd_data_o = q.rd_data;
    assign clk_out_o = q.clk_out;
    assign mode_o = q.mode;
    assign xtal_on_o = q.xtal_on;
    assign rc_on_o = q.rc_on;
    assign wake_tmo_o = q.tmo;

    default clocking pmc_cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_mode_active: assert property (
        (q.rx_en && q.osc_en) |=> mode_o == PMC_ACTIVE)
        else $error("active mode not decoded");

    a_mode_standby: assert property (
        (!q.rx_en && !q.osc_en && !q.wake && !q.eb && !q.et) |=> mode_o == PMC_STANDBY)
        else $error("standby mode not decoded");

    a_idle_xtal: assert property (
        (mode_o == PMC_IDLE) |-> xtal_on_o)
        else $error("crystal off in idle");

    a_low_starting: assert property (
        (!xtal_rdy && q.mx != PMC_MX_SLOW) |=> !clk_out_o)
        else $error("clock pin not low while crystal starts");

    a_no_clk_dis: assert property (
        q.dc |=> !clk_out_o)
        else $error("clock out while disabled");

    a_switch_gap: assert property (
        (q.mx == PMC_MX_FAST) |=> (q.mx != PMC_MX_SLOW))
        else $error("direct fast to slow switch");

    a_switch_gap_rev: assert property (
        (q.mx == PMC_MX_SLOW) |=> (q.mx != PMC_MX_FAST))
        else $error("direct slow to fast switch");

    a_fall_gate: assert property (
        (q.mx != $past(q.mx) && $past(xtal_rdy) && $past(rc_rdy))
        |-> ($past(f_fall) || $past(s_fall)))
        else $error("mux change away from a falling edge");

    a_fast_needs_xtal: assert property (
        (q.mx == PMC_MX_OFF ##1 q.mx == PMC_MX_FAST) |-> $past(xtal_rdy))
        else $error("fast clock gated before crystal ready");

    a_slow_needs_rc: assert property (
        (q.mx == PMC_MX_OFF ##1 q.mx == PMC_MX_SLOW) |-> $past(rc_rdy))
        else $error("slow clock gated before RC ready");

    a_wake_irq: assert property (
        (irq_event_i && q.ewi) |=> (q.wake ##1 xtal_on_o))
        else $error("interrupt did not wake the device");

    // The pin is a registered copy of the selected generator level.
    a_slow_pin: assert property (
        (q.mx == PMC_MX_SLOW && !q.dc) |=> clk_out_o == $past(s_lvl))
        else $error("slow clock not on the pin");

    a_fast_pin: assert property (
        (q.mx == PMC_MX_FAST && !q.dc) |=> clk_out_o == $past(f_lvl))
        else $error("fast clock not on the pin");

    a_tmo_pulse: assert property (
        wake_tmo_o |=> !wake_tmo_o)
        else $error("wake timeout longer than one cycle");

    c_slow_to_fast: cover property (q.mx == PMC_MX_SLOW ##1 q.mx == PMC_MX_OFF
        ##[1:1000] q.mx == PMC_MX_FAST);
    c_fast_to_slow: cover property (q.mx == PMC_MX_FAST ##1 q.mx == PMC_MX_OFF);
    c_wake: cover property (irq_event_i && q.ewi && q.mx == PMC_MX_SLOW);
    c_timeout: cover property (wake_tmo_o);
endmodule

// ===== design/pmc_wake_timer.sv
// Wake-up timer with calibration on enable, periodic recalibration and auto-restart.
module pmc_wake_timer
    import pmc_pkg::*;
#(
    parameter int RECAL = RECAL_TICKS
)
(
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    // Control
    input  wire logic        en_i,
    input  wire logic        tick_i,
    input  wire logic [15:0] period_i,
    input  wire logic        cal_dis_i,
    // Status
    output logic             cal_busy_o,
    output logic             timeout_o
);
    localparam int RW = $clog2(RECAL + 1);

    typedef struct packed {
        logic          en;
        logic          busy;
        logic [2:0]    cal;
        logic [15:0]   per;
        logic [RW-1:0] age;
        logic          tmo;
    } pmc_wt_s;

    pmc_wt_s q;
    pmc_wt_s d;

    always_comb
    begin
        d = q;
        d.en = en_i;
        d.tmo = 1'b0;
        if (!en_i)
        begin
            d.busy = 1'b0;
            d.per = '0;
            d.age = '0;
        end
        else if (!q.en)
        begin
            d.busy = !cal_dis_i;
            d.cal = '0;
            d.per = '0;
            d.age = '0;
        end
        else if (tick_i)
        begin
            if (q.busy)
            begin
                if (q.cal == 3'(CAL_TICKS - 1))
                    d.busy = 1'b0;
                else
                    d.cal = q.cal + 3'h1;
            end
            else
            begin
                if (q.per >= period_i)
                begin
                    d.per = '0;
                    d.tmo = 1'b1;
                end
                else
                    d.per = q.per + 16'h0001;
                if (q.age == RW'(RECAL - 1))
                begin
                    d.age = '0;
                    d.busy = !cal_dis_i;
                    d.cal = '0;
                end
                else
                    d.age = q.age + RW'(1);
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            q <= '0;
        else
            q <= d;
    end

    assign cal_busy_o = q.busy;
    assign timeout_o = q.tmo;

    a_cal_on_enable: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (en_i && !q.en && !cal_dis_i) |=> cal_busy_o) else $error("no calibration on enable");
endmodule

// ===== tb/pmc_host_model.sv
// Host microcontroller model that times the phases of the clock it is fed.
module pmc_host_model
    import pmc_pkg::*;
(
    // Clock
    input  wire logic        ref_clk_i,
    // Observed clock and measurement clear
    input  wire logic        clk_in_i,
    input  wire logic        clr_i,
    // Measurements
    output logic [15:0]      last_half_o,
    output logic [15:0]      min_half_o,
    output logic [15:0]      edge_cnt_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic        prev_q;
    logic        seen_q;
    logic [15:0] run_q;

    initial
    begin
        prev_q      = 1'b0;
        seen_q      = 1'b0;
        run_q       = 16'h0000;
        last_half_o = 16'h0000;
        min_half_o  = 16'hFFFF;
        edge_cnt_o  = 16'h0000;
    end

    // The first phase after a clear is partial, so it never lowers the minimum.
    always @(posedge ref_clk_i)
    begin
        prev_q <= clk_in_i;
        if (clr_i)
        begin
            seen_q     <= 1'b0;
            min_half_o <= 16'hFFFF;
            run_q      <= 16'h0000;
        end
        else if (clk_in_i !== prev_q)
        begin
            last_half_o <= run_q + 16'h0001;
            if (seen_q && (run_q + 16'h0001 < min_half_o))
                min_half_o <= run_q + 16'h0001;
            seen_q     <= 1'b1;
            run_q      <= 16'h0000;
            edge_cnt_o <= edge_cnt_o + 16'h0001;
        end
        else
            run_q <= run_q + 16'h0001;
    end
endmodule

// ===== tb/power_mode_clock_output_tb.sv
// Self-checking bench for the power mode and clock output controller.
module power_mode_clock_output_tb
    import pmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic              ref_clk_i = 1'b0;
    logic              rst_n_i = 1'b0;
    logic [ADDR_W-1:0] addr_i = 5'h00;
    logic [31:0]       wr_data_i = 32'h0000_0000;
    logic              wr_i = 1'b0;
    logic              rd_i = 1'b0;
    logic              irq_event_i = 1'b0;
    logic              clr = 1'b0;
    logic [31:0]       rd_data_o;
    logic              clk_out_o;
    logic [1:0]        mode_o;
    logic              xtal_on_o;
    logic              rc_on_o;
    logic              wake_tmo_o;
    logic [15:0]       last_half;
    logic [15:0]       min_half;
    logic [15:0]       edge_cnt;
    logic [31:0]       rd;
    logic [15:0]       edges0;
    int                error_cnt = 0;
    int                check_count = 0;
    int                cyc = 0;
    int                tmo_cnt = 0;

    always #5 ref_clk_i = ~ref_clk_i;

    pmc_top #(.XTAL_START(20), .RECAL(50)) dut_u (
        .ref_clk_i  (ref_clk_i),
        .rst_n_i    (rst_n_i),
        .addr_i     (addr_i),
        .wr_data_i  (wr_data_i),
        .wr_i       (wr_i),
        .rd_i       (rd_i),
        .rd_data_o  (rd_data_o),
        .irq_event_i(irq_event_i),
        .clk_out_o  (clk_out_o),
        .mode_o     (mode_o),
        .xtal_on_o  (xtal_on_o),
        .rc_on_o    (rc_on_o),
        .wake_tmo_o (wake_tmo_o)
    );

    pmc_host_model host_u (
        .ref_clk_i  (ref_clk_i),
        .clk_in_i   (clk_out_o),
        .clr_i      (clr),
        .last_half_o(last_half),
        .min_half_o (min_half),
        .edge_cnt_o (edge_cnt)
    );

    task automatic close_out();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge ref_clk_i)
    begin
        cyc = cyc + 1;
        if (wake_tmo_o === 1'b1)
            tmo_cnt = tmo_cnt + 1;
        if (cyc == 90000)
        begin
            error_cnt = error_cnt + 1;
            close_out();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count = check_count + 1;
        if (seen !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        addr_i    <= a;
        wr_data_i <= d;
        wr_i      <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rdr(input logic [4:0] a, output logic [31:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        @(negedge ref_clk_i);
        d = rd_data_o;
    endtask

    // Polls the status register until the clock mux reports the wanted source.
    task automatic wait_mux(input logic [1:0] m);
        logic [31:0] s;
        s = 32'h0000_0000;
        for (int i = 0; i < 4000 && s[5:4] !== m; i++)
            rdr(OFF_STAT, s);
        check("mux source", 32'(s[5:4]), 32'(m));
    endtask

    logic [6:0] ctl_tab [5] = '{7'h02, 7'h03, 7'h00, 7'h08, 7'h04};
    logic [1:0] mode_tab[5] = '{2'h2, 2'h3, 2'h0, 2'h1, 2'h1};

    initial
    begin
        wt(12);
        rst_n_i <= 1'b1;
        wt(500);
        check("pin low before rc", 32'(edge_cnt), 32'h0);
        check("mode after reset", 32'(mode_o), 32'h1);
        rdr(OFF_CTRL, rd);
        check("ctrl reset", rd, 32'h28);
        rdr(OFF_DIV, rd);
        check("div reset", rd, 32'h5);
        rdr(OFF_EXTF, rd);
        check("extf reset", rd, 32'h0);
        rdr(OFF_WTPER, rd);
        check("wtper reset", rd, 32'h100);
        rdr(5'h14, rd);
        check("unmapped read", rd, 32'h0);
        wt(8000);
        check("slow half", 32'(last_half), 32'(SLOW_HALF));
        clr <= 1'b1;
        wt(1);
        clr <= 1'b0;
        wr(OFF_CTRL, 32'h2A);
        wt(3);
        check("mode idle", 32'(mode_o), 32'h2);
        check("xtal on", 32'(xtal_on_o), 32'h1);
        wait_mux(2'h1);
        wt(400);
        check("fast half", 32'(last_half), 32'(XTAL_HALF * 10));
        check("min phase", 32'(min_half >= 16'(XTAL_HALF * 10)), 32'h1);
        wr(OFF_DIV, 32'h4);
        wt(200);
        check("divided half", 32'(last_half), 32'(XTAL_HALF * 5));
        wr(OFF_CTRL, 32'h2B);
        wt(3);
        check("mode active", 32'(mode_o), 32'h3);
        wr(OFF_CTRL, 32'h28);
        wait_mux(2'h2);
        wt(4000);
        check("slow again", 32'(last_half), 32'(SLOW_HALF));
        wr(OFF_CTRL, 32'h38);
        wt(10);
        edges0 = edge_cnt;
        wt(4000);
        check("disabled edges", 32'(edge_cnt), 32'(edges0));
        for (int i = 0; i < 5; i++)
        begin
            wr(OFF_CTRL, 32'(ctl_tab[i]));
            wt(3);
            check("mode table", 32'(mode_o), 32'(mode_tab[i]));
        end
        wt(10);
        edges0 = edge_cnt;
        wt(4000);
        check("sleep no fast", 32'(edge_cnt), 32'(edges0));
        check("sleep pin low", 32'(clk_out_o), 32'h0);
        wr(OFF_WTPER, 32'h0);
        wr(OFF_CTRL, 32'h08);
        rdr(OFF_STAT, rd);
        check("cal busy", 32'(rd[6]), 32'h1);
        check("rc on", 32'(rc_on_o), 32'h1);
        tmo_cnt = 0;
        wt(28000);
        check("restarts", 32'(tmo_cnt >= 3), 32'h1);
        wr(OFF_EXTF, 32'h10);
        rdr(OFF_EXTF, rd);
        check("cal disable", rd, 32'h10);
        wr(OFF_CTRL, 32'h48);
        wt(3);
        check("woi sleep", 32'(mode_o), 32'h1);
        @(posedge ref_clk_i);
        irq_event_i <= 1'b1;
        @(posedge ref_clk_i);
        irq_event_i <= 1'b0;
        wt(4);
        check("wake xtal", 32'(xtal_on_o), 32'h1);
        rdr(OFF_STAT, rd);
        check("wake flag", 32'(rd[7]), 32'h1);
        close_out();
    end
endmodule
